//--- hw/spsc_phase_step_ctrl.sv
`timescale 1ns/100ps
module spsc_phase_step_ctrl
	import spsc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        regWrStrobe,
	input  wire logic        regRdStrobe,
	input  wire logic [5:0]  regAddr,
	input  wire logic [15:0] regWrData,
	output logic      [15:0] regRdData,
	output logic             regRdValid,
	output logic             regParityErr,
	input  wire logic        stepPinUse,
	input  wire logic        directionPinUse,
	input  wire logic [1:0]  thirdInputFunction,
	input  wire logic        stallDetectedFlag,
	input  wire logic        autoHoldOnStall,
	input  wire logic        pwmPeriodStart,
	input  wire logic        stepInputPin,
	input  wire logic        directionInputPin,
	input  wire logic        modeOrHoldInputPin,
	output logic             bridgeEnable,
	output logic             holdActive,
	output logic      [2:0]  activeResolution,
	output logic      [5:0]  phasePositionCounter,
	output logic             stepDirection
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic stepSync;
	logic dirSync;
	logic modeSync;

	spsc_sync uStepSync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.pinAsync(stepInputPin),
		.pinSync (stepSync)
	);
	spsc_sync uDirSync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.pinAsync(directionInputPin),
		.pinSync (dirSync)
	);
	spsc_sync uModeSync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.pinAsync(modeOrHoldInputPin),
		.pinSync (modeSync)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic        enable_q,    enable_d;
	logic        hold_q,      hold_d;
	logic [2:0]  altRes_q,    altRes_d;
	logic [2:0]  primRes_q,   primRes_d;
	logic        dir_q,       dir_d;
	logic [5:0]  phase_q,     phase_d;
	logic [5:0]  pending_q,   pending_d;
	logic        pendValid_q, pendValid_d;
	logic        stepPrev_q,  stepPrev_d;
	logic [2:0]  actRes_q,    actRes_d;
	logic [15:0] rdData_q,    rdData_d;
	logic        rdValid_q,   rdValid_d;
	logic        parErr_q,    parErr_d;

	logic        wrHit;
	logic        wrOk;
	logic        stepEdge;
	logic        useAlt;
	logic [5:0]  stride;
	logic [15:0] image;

	// ----------------------------------------
	// Control next state
	// ----------------------------------------
	always_comb begin
		wrHit = regWrStrobe && (regAddr == MOTOR_STEP_CONTROL_ONE_ADDR);
		// Odd parity over the whole frame, P included
		wrOk = wrHit && (^regWrData);
		// Edge only counts while the pin is the step input
		stepEdge = stepPinUse && stepSync && !stepPrev_q;
		useAlt = stepPinUse && (thirdInputFunction == THIRD_FN_MODE)
			&& modeSync;
		stride = useAlt ? spsc_stride(spsc_decode(altRes_q))
			: spsc_stride(spsc_decode(primRes_q));

		enable_d    = enable_q;
		hold_d      = hold_q;
		altRes_d    = altRes_q;
		primRes_d   = primRes_q;
		dir_d       = dir_q;
		phase_d     = phase_q;
		pending_d   = pending_q;
		pendValid_d = pendValid_q;
		stepPrev_d  = stepSync;

		if (wrOk) begin
			enable_d  = regWrData[ENABLE_BIT];
			altRes_d  = regWrData[ALT_MSB:ALT_LSB];
			primRes_d = regWrData[PRIM_MSB:PRIM_LSB];
			// Unless the pin owns hold, a set always lands; a clear is held off during stall hold
			if (regWrData[HOLD_BIT] ||
				!(stallDetectedFlag && autoHoldOnStall)) begin
				hold_d = regWrData[HOLD_BIT];
			end
			if (!directionPinUse) begin
				dir_d = regWrData[DIR_BIT];
			end
		end

		// Pin ownership overrides host writes
		if (thirdInputFunction == THIRD_FN_HOLD) begin
			hold_d = modeSync;
		end
		if (directionPinUse) begin
			dir_d = dirSync;
		end

		if (stepPinUse) begin
			pendValid_d = 1'b0;
			if (stepEdge) begin
				// 6-bit arithmetic wraps modulo 64 by itself
				phase_d = dir_q ? phase_q - stride
					: phase_q + stride;
			end
		end else begin
			if (pwmPeriodStart && pendValid_q) begin
				phase_d     = pending_q;
				pendValid_d = 1'b0;
			end
			// A write in the same cycle waits for the next period
			if (wrOk) begin
				pending_d   = regWrData[PHASE_MSB:PHASE_LSB];
				pendValid_d = 1'b1;
			end
		end

		// Registered so the shown code moves with the stride it names
		actRes_d = useAlt ? altRes_q : primRes_q;
	end

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	always_comb begin
		image = 16'h0000;
		if (regAddr == MOTOR_STEP_CONTROL_ONE_ADDR) begin
			image[ENABLE_BIT]          = enable_q;
			image[HOLD_BIT]            = hold_q;
			image[ALT_MSB:ALT_LSB]     = altRes_q;
			image[PRIM_MSB:PRIM_LSB]   = primRes_q;
			image[DIR_BIT]             = dir_q;
			// Shows the applied angle, not the pending one
			image[PHASE_MSB:PHASE_LSB] = phase_q;
		end
		// Parity is made last so it covers whatever the image holds
		image[PARITY_BIT] = ~(^image[15:1]);
		rdData_d  = regRdStrobe ? image : rdData_q;
		rdValid_d = regRdStrobe;
		parErr_d  = wrHit && !wrOk;
	end

	// Frame holds until the next read, so a slow host may fetch it late
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdData_q  <= 16'h0000;
			rdValid_q <= 1'b0;
			parErr_q  <= 1'b0;
		end else begin
			rdData_q  <= rdData_d;
			rdValid_q <= rdValid_d;
			parErr_q  <= parErr_d;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// Pending phase is cleared on reset, so no stale write lands later
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			enable_q    <= MOTOR_STEP_CONTROL_ONE_RST[ENABLE_BIT];
			hold_q      <= MOTOR_STEP_CONTROL_ONE_RST[HOLD_BIT];
			altRes_q    <= MOTOR_STEP_CONTROL_ONE_RST[ALT_MSB:ALT_LSB];
			primRes_q   <= MOTOR_STEP_CONTROL_ONE_RST[PRIM_MSB:PRIM_LSB];
			dir_q       <= MOTOR_STEP_CONTROL_ONE_RST[DIR_BIT];
			phase_q     <= MOTOR_STEP_CONTROL_ONE_RST[PHASE_MSB:PHASE_LSB];
			pending_q   <= 6'h00;
			pendValid_q <= 1'b0;
			stepPrev_q  <= 1'b0;
			actRes_q    <= 3'h0;
		end else begin
			enable_q    <= enable_d;
			hold_q      <= hold_d;
			altRes_q    <= altRes_d;
			primRes_q   <= primRes_d;
			dir_q       <= dir_d;
			phase_q     <= phase_d;
			pending_q   <= pending_d;
			pendValid_q <= pendValid_d;
			stepPrev_q  <= stepPrev_d;
			actRes_q    <= actRes_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Bridge logic outside turns all switches off while this is low
	assign bridgeEnable         = enable_q;
	assign holdActive           = hold_q;
	assign activeResolution     = actRes_q;
	assign phasePositionCounter = phase_q;
	assign stepDirection        = dir_q;
	assign regRdData            = rdData_q;
	assign regRdValid           = rdValid_q;
	assign regParityErr         = parErr_q;
endmodule

//--- hw/spsc_pkg.sv
package spsc_pkg;

	localparam logic [5:0]  MOTOR_STEP_CONTROL_ONE_ADDR = 6'h05;
	localparam logic [15:0] MOTOR_STEP_CONTROL_ONE_RST  = 16'h0000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ENABLE_BIT = 15;
	localparam int HOLD_BIT   = 14;
	localparam int ALT_MSB    = 13;
	localparam int ALT_LSB    = 11;
	localparam int PRIM_MSB   = 10;
	localparam int PRIM_LSB   = 8;
	localparam int DIR_BIT    = 7;
	localparam int PHASE_MSB  = 6;
	localparam int PHASE_LSB  = 1;
	localparam int PARITY_BIT = 0;

	localparam logic [1:0] THIRD_FN_MODE = 2'h1;
	localparam logic [1:0] THIRD_FN_HOLD = 2'h2;

	typedef enum logic [2:0] {
		SPSC_RES_SIXTEENTH = 3'h0,
		SPSC_RES_EIGHTH    = 3'h1,
		SPSC_RES_MINI      = 3'h2,
		SPSC_RES_HALF      = 3'h3,
		SPSC_RES_FULL      = 3'h4
	} spsc_res_t;

	// Codes 101..111 fold onto 1/16, so they step the counter by a stride of 1
	function automatic spsc_res_t spsc_decode(input logic [2:0] code);
		spsc_res_t r;
		case (code)
			3'h1: r = SPSC_RES_EIGHTH;
			3'h2: r = SPSC_RES_MINI;
			3'h3: r = SPSC_RES_HALF;
			3'h4: r = SPSC_RES_FULL;
			default: r = SPSC_RES_SIXTEENTH;
		endcase
		return r;
	endfunction

	function automatic logic [5:0] spsc_stride(input spsc_res_t r);
		logic [5:0] s;
		case (r)
			SPSC_RES_EIGHTH: s = 6'h02;
			SPSC_RES_MINI:   s = 6'h04;
			SPSC_RES_HALF:   s = 6'h08;
			SPSC_RES_FULL:   s = 6'h10;
			default:         s = 6'h01;
		endcase
		return s;
	endfunction

endpackage

//--- hw/spsc_sync.sv
`timescale 1ns/100ps
module spsc_sync
	import spsc_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic pinAsync,
	output logic      pinSync
);
	logic stage1_q;
	logic stage2_q;

	// First stage feeds only the second one
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
		end else begin
			stage1_q <= pinAsync;
			stage2_q <= stage1_q;
		end
	end

	assign pinSync = stage2_q;
endmodule

//--- bench/spsc_checker.sv
`timescale 1ns/100ps
module spsc_checker
	import spsc_pkg::*;
(
	input logic        sys_clk,
	input logic        srst,
	input logic        regWrStrobe,
	input logic        regRdStrobe,
	input logic [5:0]  regAddr,
	input logic [15:0] regWrData,
	input logic [15:0] regRdData,
	input logic        regRdValid,
	input logic        regParityErr,
	input logic        stepPinUse,
	input logic [1:0]  thirdInputFunction,
	input logic        stallDetectedFlag,
	input logic        autoHoldOnStall,
	input logic        pwmPeriodStart,
	input logic        bridgeEnable,
	input logic        holdActive,
	input logic [5:0]  phasePositionCounter
);
	logic gw;
	assign gw = regWrStrobe && regAddr == MOTOR_STEP_CONTROL_ONE_ADDR;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_read_valid: assert property (regRdStrobe |=> regRdValid)
		else $error("read valid missing");
	a_read_parity: assert property (regRdValid |-> ^regRdData)
		else $error("read frame parity even");
	a_read_unmapped: assert property (regRdStrobe && regAddr !=
		MOTOR_STEP_CONTROL_ONE_ADDR |=> regRdData == 16'h0001)
		else $error("unmapped read frame wrong");
	a_read_stable: assert property (!regRdStrobe
		|=> $stable(regRdData))
		else $error("read frame moved");
	a_write_parity: assert property (gw && !(^regWrData)
		|=> regParityErr)
		else $error("bad parity not flagged");
	a_enable_write: assert property (gw && ^regWrData
		|=> bridgeEnable == $past(regWrData[ENABLE_BIT]))
		else $error("enable not written");
	a_hold_keep: assert property (stallDetectedFlag
		&& autoHoldOnStall && holdActive
		&& thirdInputFunction != THIRD_FN_HOLD |=> holdActive)
		else $error("hold cleared under stall");
	a_phase_stable: assert property (!stepPinUse && !pwmPeriodStart
		|=> $stable(phasePositionCounter))
		else $error("phase moved between periods");
endmodule
bind spsc_phase_step_ctrl spsc_checker u_spsc_checker (.*);

//--- bench/spsc_pin_model.sv
`timescale 1ns/100ps
module spsc_pin_model (
	input  logic sys_clk,
	input  logic go,
	input  logic dirLevel,
	input  logic modeLevel,
	output logic stepInputPin,
	output logic directionInputPin,
	output logic modeOrHoldInputPin,
	output logic busy
);
	logic [3:0] cnt_q = 4'h0;
	always_ff @(posedge sys_clk) begin
		if (go && cnt_q == 4'h0) begin
			cnt_q <= 4'h8;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	// Four cycles high then four low, so the two-stage sync sees each level
	assign stepInputPin       = cnt_q > 4'h4;
	assign directionInputPin  = dirLevel;
	assign modeOrHoldInputPin = modeLevel;
	assign busy               = cnt_q != 4'h0;
endmodule

//--- bench/spsc_phase_step_ctrl_tb_top.sv
`timescale 1ns/100ps
module spsc_phase_step_ctrl_tb_top
	import spsc_pkg::*;
;
	logic        sys_clk = 0, srst = 1, regWrStrobe = 0, regRdStrobe = 0;
	logic        stepPinUse = 0, directionPinUse = 0, stallDetectedFlag = 0;
	logic        autoHoldOnStall = 0, pwmPeriodStart = 0, go = 0;
	logic        dirLevel = 0, modeLevel = 0, busy, stepInputPin;
	logic        directionInputPin, modeOrHoldInputPin, regRdValid;
	logic        regParityErr, bridgeEnable, holdActive, stepDirection;
	logic [1:0]  thirdInputFunction = 2'h0;
	logic [2:0]  activeResolution;
	logic [5:0]  regAddr = 6'h05, phasePositionCounter, ph;
	logic [15:0] regWrData = 16'h0000, regRdData;
	int          errors = 0, checks_done = 0, i;
	int          st[8] = '{1, 2, 4, 8, 16, 1, 1, 1};
	spsc_phase_step_ctrl u_spsc_phase_step_ctrl (.*);
	spsc_pin_model u_spsc_pin_model (.*);
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic c(string n, logic [15:0] e, logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Odd parity over the whole frame
	function automatic logic [15:0] f(logic [15:0] d);
		return {d[15:1], ~^d[15:1]};
	endfunction
	task automatic w(logic [15:0] d);
		@(posedge sys_clk);
		regWrStrobe <= 1;
		regWrData <= d;
		@(posedge sys_clk);
		regWrStrobe <= 0;
		#1;
	endtask
	task automatic r(logic [5:0] a, logic [15:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStrobe <= 1;
		@(posedge sys_clk);
		regRdStrobe <= 0;
		regAddr <= 6'h05;
		#1;
		c("valid", 1, regRdValid);
		c("frame", e, regRdData);
	endtask
	task automatic s(int d);
		repeat (6) @(posedge sys_clk);
		go <= 1;
		@(posedge sys_clk);
		go <= 0;
		repeat (12) @(posedge sys_clk);
		#1;
		ph = ph + d[5:0];
		c("phase", ph, phasePositionCounter);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 0;
		#1;
		r(6'h05, 16'h0001);
		r(6'h07, 16'h0001);
		w(f(16'hC40A));
		c("enable", 1, bridgeEnable);
		c("hold", 1, holdActive);
		r(6'h05, f(16'hC400));
		@(posedge sys_clk);
		pwmPeriodStart <= 1;
		@(posedge sys_clk);
		pwmPeriodStart <= 0;
		@(posedge sys_clk);
		r(6'h05, f(16'hC40A));
		w(16'h0000);
		c("perr", 1, regParityErr);
		c("enable", 1, bridgeEnable);
		@(posedge sys_clk);
		stallDetectedFlag <= 1;
		autoHoldOnStall <= 1;
		w(f(16'h840A));
		c("hold", 1, holdActive);
		@(posedge sys_clk);
		stallDetectedFlag <= 0;
		w(f(16'h840A));
		c("hold", 0, holdActive);
		@(posedge sys_clk);
		stepPinUse <= 1;
		ph = 6'h05;
		for (i = 0; i < 8; i++) begin
			w(f({5'h10, i[2:0], 8'h00}));
			s(st[i]);
			c("res", i[2:0], activeResolution);
		end
		w(f(16'h8480));
		for (i = 0; i < 3; i++) s(-16);
		@(posedge sys_clk);
		thirdInputFunction <= 2'h1;
		modeLevel <= 1;
		w(f(16'h9400));
		s(4);
		modeLevel <= 0;
		s(16);
		@(posedge sys_clk);
		directionPinUse <= 1;
		dirLevel <= 1;
		s(-16);
		c("dir", 1, stepDirection);
		@(posedge sys_clk);
		thirdInputFunction <= 2'h2;
		modeLevel <= 1;
		stepPinUse <= 0;
		s(0);
		c("hold", 1, holdActive);
		w(f(16'h0000));
		c("enable", 0, bridgeEnable);
		test_done;
	end
	// Whole sequence runs in well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		test_done;
	end
endmodule
